// *** shared/bbsr_pkg.sv ***
/*
  bbsr_pkg: register offsets, field positions, reset values, timing and
  carrier types of the baseband status and programming register bank.
  assumes a 20 MHz clock and a host port that presents decoded single-cycle
  read and write strobes with an 8-bit register address.
*/
package bbsr_pkg;
  localparam logic [7:0]  ADDR_ADC    = 8'hb4;
  localparam logic [7:0]  ADDR_STATUS = 8'hc6;
  localparam logic [7:0]  ADDR_PROG   = 8'hc8;
  localparam logic [7:0]  ADDR_TONE   = 8'hcc;
  localparam logic [7:0]  ADDR_RXDATA = 8'hc5;
  localparam int          BIT_IRQ     = 15;
  localparam int          BIT_SELC    = 13;
  localparam int          BIT_CTC     = 11;
  localparam int          BIT_DCS     = 10;
  localparam int          BIT_ADCH    = 9;
  localparam int          BIT_ADCL    = 8;
  localparam int          BIT_TXEND   = 7;
  localparam int          BIT_XFER    = 6;
  localparam int          BIT_RATE_LO = 3;
  localparam int          BIT_SYNC_LO = 1;
  localparam int          BIT_PROG    = 0;
  localparam logic [15:0] STATUS_RST  = 16'h0001;
  localparam logic [15:0] STATUS_USED = 16'hafdf;
  localparam int          CLK_HZ      = 20_000_000;
  localparam int          PROG_TIME_NS = 250_000;
  localparam int          PROG_CYCLES  = (PROG_TIME_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int          BLK_WORDS   = 19;
  localparam logic [2:0]  BLK_SEL0    = 3'b100;
  localparam logic [2:0]  BLK_SEL1    = 3'b101;
  localparam logic [2:0]  BLK_SEL2    = 3'b110;

  typedef enum logic [2:0] {
    BBSR_BLK0, BBSR_BLK1, BBSR_BLK2, BBSR_BLK4, BBSR_BLKX
  } bbsr_blk_t;

  // events from the modem, tone and adc datapaths
  typedef struct packed {
    logic       tx_mode;
    logic       adc_valid;
    logic [7:0] adc_value;
    logic       adc_above;
    logic       adc_below;
    logic       tx_last_done;
    logic       xfer_req;
    logic       sync_valid;
    logic [1:0] sync_rate;
    logic [1:0] sync_pattern;
    logic       rx_byte_valid;
    logic [7:0] rx_byte;
    logic       rx_check_ok;
    logic       ctcss_en;
    logic       dcs_en;
    logic       selcall_en;
    logic [5:0] ctcss_code;
    logic [2:0] subaudio_code;
    logic [4:0] selcall_code;
  } bbsr_evt_t;

  // one decoded programming word
  typedef struct packed {
    logic       valid;
    bbsr_blk_t  block;
    logic [4:0] index;
    logic [13:0] data;
  } bbsr_prog_t;
endpackage : bbsr_pkg

// *** hw/bbsr_prog_port.sv ***
/*
  bbsr_prog_port: decodes programming words into block, index and data,
  and paces the ready flag. assumes the host follows the ready flag.
*/
module bbsr_prog_port
  import bbsr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // host write
  input  wire logic        wr_stb,
  input  wire logic [15:0] wr_data,
  // decoded output
  output bbsr_prog_t       prog_word,
  output logic             prog_ready
);
  localparam logic [13:0] PROG_CNT = 14'(PROG_CYCLES);

  logic [13:0] cnt_q, cnt_d;
  logic        rdy_q, rdy_d;
  bbsr_prog_t  word_q, word_d;
  bbsr_blk_t   blk_q, blk_d;
  logic [4:0]  idx_q, idx_d;

  always_comb begin
    bbsr_blk_t  sel;
    logic [4:0] idx;
    sel = BBSR_BLKX;
    idx = idx_q;
    cnt_d = cnt_q;
    rdy_d = rdy_q;
    blk_d = blk_q;
    word_d = word_q;
    word_d.valid = 1'b0;
    if (!wr_data[14]) begin
      sel = BBSR_BLK4;
    end else begin
      case (wr_data[14:12])
        BLK_SEL0: sel = BBSR_BLK0;
        BLK_SEL1: sel = BBSR_BLK1;
        BLK_SEL2: sel = BBSR_BLK2;
        default:  sel = BBSR_BLKX;
      endcase
    end
    if (wr_stb) begin
      rdy_d = 1'b0;
      cnt_d = PROG_CNT;
      idx = wr_data[15] ? 5'd0 : ((idx_q < 5'(BLK_WORDS - 1)) ? idx_q + 5'd1 : idx_q);
      blk_d = sel;
      idx_d = idx;
      word_d.valid = (sel != BBSR_BLKX);
      word_d.block = sel;
      word_d.index = idx;
      word_d.data = (sel == BBSR_BLK4) ? wr_data[13:0] : {2'b00, wr_data[11:0]};
    end else begin
      idx_d = idx_q;
      if (!rdy_q) begin
        if (cnt_q <= 14'd1) begin
          rdy_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 14'd1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      rdy_q <= 1'b1;
      blk_q <= BBSR_BLKX;
      idx_q <= '0;
      word_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      blk_q <= blk_d;
      idx_q <= idx_d;
      word_q <= word_d;
    end
  end

  assign prog_word = word_q;
  assign prog_ready = rdy_q;

  ready_back_a: assert property (@(posedge clk) disable iff (rst)
    wr_stb |=> !prog_ready [*8]) else $error("ready returned too early");
  prog_clear_a: assert property (@(posedge clk) disable iff (rst)
    wr_stb |=> !prog_ready) else $error("ready not cleared");
  resv_block_a: assert property (@(posedge clk) disable iff (rst)
    (wr_stb && wr_data[14:12] == 3'b111) |=> !prog_word.valid)
    else $error("reserved block forwarded");
  prog_write_c: cover property (@(posedge clk) disable iff (rst) wr_stb ##1 prog_word.valid);
endmodule : bbsr_prog_port

// *** hw/bbsr_regs.sv ***
/*
  bbsr_regs: host status and programming register bank; status word,
  interrupt request, aux adc result, receive data and tone status.
  assumes the host port delivers one-cycle rd_stb and wr_stb with an
  8-bit address, and that datapath events arrive on the same clock.
*/
module bbsr_regs
  import bbsr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // host register port
  input  wire logic [7:0]  addr,
  input  wire logic        rd_stb,
  input  wire logic        wr_stb,
  input  wire logic [15:0] wr_data,
  output logic [15:0]      rd_data,
  // interrupt mask from mask register
  input  wire logic [15:0] irq_mask,
  // datapath events
  input  bbsr_evt_t        evt,
  // programming output
  output bbsr_prog_t       prog_word,
  // interrupt
  output logic             interrupt_request_n
);
  logic [15:0] status_q, status_d;
  logic [7:0]  adc_q, adc_d;
  logic [15:0] rxw_q, rxw_d;
  logic [15:0] tone_q, tone_d;
  logic [15:0] rdat_q, rdat_d;
  logic        irq_q, irq_d;
  logic        prog_ready;
  logic        prog_wr;
  logic        stat_rd;
  logic [15:0] set_v;
  logic [15:0] tone_n;

  assign prog_wr = wr_stb && (addr == ADDR_PROG);
  assign stat_rd = rd_stb && (addr == ADDR_STATUS);

  bbsr_prog_port u_prog (
    .clk        (clk),
    .rst        (rst),
    .wr_stb     (prog_wr),
    .wr_data    (wr_data),
    .prog_word  (prog_word),
    .prog_ready (prog_ready)
  );

  // tone word next value
  always_comb begin
    tone_n = '0;
    if (!evt.tx_mode) begin
      if (evt.selcall_en) begin
        tone_n[15:11] = evt.selcall_code;
      end
      if (evt.dcs_en && evt.subaudio_code != 3'b000) begin
        tone_n[10:8] = evt.subaudio_code;
      end else if (evt.ctcss_en) begin
        tone_n[5:0] = evt.ctcss_code;
      end
    end
  end

  // status set sources
  always_comb begin
    set_v = '0;
    if (!evt.tx_mode) begin
      set_v[BIT_SELC] = tone_n[15:11] != tone_q[15:11];
      set_v[BIT_CTC]  = tone_n[5:0] != tone_q[5:0];
      set_v[BIT_DCS]  = tone_n[10:8] != tone_q[10:8];
    end
    set_v[BIT_ADCH] = evt.adc_valid && evt.adc_above;
    set_v[BIT_ADCL] = evt.adc_valid && evt.adc_below;
    // end of transmission only in transmit
    set_v[BIT_TXEND] = evt.tx_mode && evt.tx_last_done;
    set_v[BIT_XFER] = evt.tx_mode ? evt.xfer_req : evt.rx_byte_valid;
    if (evt.sync_valid && !evt.tx_mode) begin
      set_v[4:3] = evt.sync_rate;
      set_v[2:1] = evt.sync_pattern;
    end
  end

  always_comb begin
    logic [15:0] nxt;
    nxt = status_q;
    if (stat_rd) begin
      nxt[15:1] = '0;
    end
    nxt[15:1] = nxt[15:1] | set_v[15:1];
    if (evt.tx_mode) begin
      nxt[BIT_SELC] = 1'b0;
      nxt[BIT_CTC] = 1'b0;
      nxt[BIT_DCS] = 1'b0;
    end else begin
      nxt[BIT_TXEND] = 1'b0;
    end
    // ready flag follows programming port only
    nxt[BIT_PROG] = prog_ready;
    if (|((nxt[14:0] ^ status_q[14:0]) & nxt[14:0] & irq_mask[14:0] & STATUS_USED[14:0])) begin
      nxt[BIT_IRQ] = 1'b1;
    end
    status_d = nxt & STATUS_USED;
    // request pin gated by global mask
    irq_d = status_d[BIT_IRQ] && irq_mask[BIT_IRQ];
    adc_d = evt.adc_valid ? evt.adc_value : adc_q;
    // receive byte overwrite and check flag
    rxw_d = rxw_q;
    if (evt.rx_byte_valid) begin
      rxw_d = {6'b00_0000, evt.rx_check_ok, 1'b0, evt.rx_byte};
    end
    tone_d = tone_n;
    case (addr)
      ADDR_ADC:    rdat_d = {8'h00, adc_q};
      ADDR_STATUS: rdat_d = status_q;
      ADDR_TONE:   rdat_d = tone_q;
      ADDR_RXDATA: rdat_d = rxw_q;
      default:     rdat_d = '0;
    endcase
    if (!rd_stb) begin
      rdat_d = rdat_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= STATUS_RST;
      adc_q <= '0;
      rxw_q <= '0;
      tone_q <= '0;
      rdat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      adc_q <= adc_d;
      rxw_q <= rxw_d;
      tone_q <= tone_d;
      rdat_q <= rdat_d;
      irq_q <= irq_d;
    end
  end

  assign rd_data = rdat_q;
  assign interrupt_request_n = !irq_q;

  irq_pin_a: assert property (@(posedge clk) disable iff (rst)
    interrupt_request_n == !(status_q[BIT_IRQ] && $past(irq_mask[BIT_IRQ])))
    else $error("request pin mismatch");
  read_clear_a: assert property (@(posedge clk) disable iff (rst)
    (stat_rd && set_v == '0) |=> status_q[15:1] == '0 || $past(irq_mask) != '0)
    else $error("status not cleared");
  prog_flag_a: assert property (@(posedge clk) disable iff (rst)
    status_q[BIT_PROG] == $past(prog_ready)) else $error("ready flag mismatch");
  tx_tone_a: assert property (@(posedge clk) disable iff (rst)
    evt.tx_mode |=> tone_q == '0 && status_q[13] == 1'b0) else $error("tone in transmit");
  adc_latch_a: assert property (@(posedge clk) disable iff (rst)
    evt.adc_valid |=> adc_q == $past(evt.adc_value)) else $error("adc not latched");
  set_wins_a: assert property (@(posedge clk) disable iff (rst)
    (stat_rd && set_v[BIT_XFER]) |=> status_q[BIT_XFER]) else $error("event lost");
  rx_byte_a: assert property (@(posedge clk) disable iff (rst)
    evt.rx_byte_valid |=> rxw_q[7:0] == $past(evt.rx_byte)) else $error("rx byte lost");
  masked_irq_a: assert property (@(posedge clk) disable iff (rst)
    (irq_mask[BIT_ADCH] && set_v[BIT_ADCH] && !status_q[BIT_ADCH]) |=> status_q[BIT_IRQ])
    else $error("irq not set");

  irq_c: cover property (@(posedge clk) disable iff (rst) !interrupt_request_n);
  rd_clear_c: cover property (@(posedge clk) disable iff (rst) stat_rd && status_q[15]);
  tone_c: cover property (@(posedge clk) disable iff (rst) set_v[BIT_CTC]);
endmodule : bbsr_regs

// *** verif/bbsr_host.sv ***
/*
  bbsr_host: host model on the register port of the status bank.
  assumes its tasks are entered just after a rising clock edge.
*/
module bbsr_host
  import bbsr_pkg::*;
(
  // clock
  input  wire logic        clk,
  // register port
  output logic [7:0]       addr,
  output logic             rd_stb,
  output logic             wr_stb,
  output logic [15:0]      wr_data,
  input  wire logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    addr    = 8'h00;
    rd_stb  = 1'b0;
    wr_stb  = 1'b0;
    wr_data = 16'h0000;
  end

  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    addr   = a;
    rd_stb = 1'b1;
    @(posedge clk);
    #1;
    rd_stb = 1'b0;
    d      = rd_data;
    // idle edge so a following strobe never rises in the same step
    @(posedge clk);
    #1;
  endtask : reg_rd

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    addr    = a;
    wr_data = d;
    wr_stb  = 1'b1;
    @(posedge clk);
    #1;
    wr_stb  = 1'b0;
    @(posedge clk);
    #1;
  endtask : reg_wr

  // write in order, only once ready
  task automatic prog_wr(input logic [15:0] d, output bit ok);
    logic [15:0] s;
    ok = 1'b0;
    for (int i = 0; i < 4000 && !ok; i++) begin
      reg_rd(ADDR_STATUS, s);
      ok = (s[BIT_PROG] === 1'b1);
    end
    if (ok) reg_wr(ADDR_PROG, d);
  endtask : prog_wr
endmodule : bbsr_host

// *** verif/baseband_status_and_programming_regs_bench.sv ***
/*
  bench for bbsr_regs: drives datapath events, talks through bbsr_host.
  assumes a 20 MHz clock and synchronous active high reset.
*/
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module baseband_status_and_programming_regs_bench
  import bbsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr;
  logic        rd_stb, wr_stb, interrupt_request_n;
  logic [15:0] wr_data, rd_data, d;
  logic [15:0] irq_mask = 16'h0000;
  bbsr_evt_t   evt = '0;
  bbsr_prog_t  prog_word, last_prog;
  int          bad_count = 0, tests_run = 0, prog_cnt = 0;
  bit          ok;

  always #25 clk = ~clk;

  bbsr_regs DUT (.clk(clk), .rst(rst), .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_data(rd_data), .irq_mask(irq_mask), .evt(evt),
    .prog_word(prog_word), .interrupt_request_n(interrupt_request_n));
  bbsr_host u_host (.clk(clk), .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_data(rd_data));

  always @(posedge clk) begin
    if (prog_word.valid === 1'b1) begin
      last_prog <= prog_word;
      prog_cnt  <= prog_cnt + 1;
    end
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] g;
    u_host.reg_rd(a, g);
    `CHK(n, e, g)
  endtask : rd_chk

  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic t_reset();
    `CHK("irq pin", 1'b1, interrupt_request_n)
    `CHK("prog word", '0, prog_word)
    rd_chk("status", ADDR_STATUS, 16'h0001);
    rd_chk("unmapped", 8'h10, 16'h0000);
  endtask : t_reset

  task automatic t_adc();
    evt.adc_value = 8'h5a;
    {evt.adc_valid, evt.adc_above, evt.adc_below} = 3'b111;
    tick();
    {evt.adc_valid, evt.adc_above, evt.adc_below} = 3'b000;
    tick();
    rd_chk("adc", ADDR_ADC, 16'h005a);
    rd_chk("status", ADDR_STATUS, 16'h0301);
    rd_chk("status", ADDR_STATUS, 16'h0001);
  endtask : t_adc

  task automatic t_irq(input logic [15:0] m, input logic [15:0] s, input logic q);
    irq_mask = m;
    // receive mode: a ready byte raises the transfer flag
    evt.rx_byte_valid = 1'b1;
    tick();
    evt.rx_byte_valid = 1'b0;
    tick(3);
    `CHK("irq pin", q, interrupt_request_n)
    rd_chk("status", ADDR_STATUS, s);
    tick(3);
    `CHK("irq pin", 1'b1, interrupt_request_n)
  endtask : t_irq

  task automatic t_sync();
    logic [1:0] r;
    for (int i = 1; i < 4; i++) begin
      r = (i == 1) ? 2'b01 : 2'b10;
      evt.sync_rate = r;
      evt.sync_pattern = 2'(i);
      evt.sync_valid = 1'b1;
      tick();
      evt.sync_valid = 1'b0;
      tick();
      rd_chk("sync", ADDR_STATUS, {11'h000, r, 2'(i), 1'b1});
    end
  endtask : t_sync

  task automatic rx_byte(input logic [7:0] b, input logic c);
    evt.rx_byte = b;
    evt.rx_check_ok = c;
    evt.rx_byte_valid = 1'b1;
    tick();
    evt.rx_byte_valid = 1'b0;
    tick();
  endtask : rx_byte

  task automatic t_rx();
    rx_byte(8'h3c, 1'b1);
    rd_chk("rx word", ADDR_RXDATA, 16'h023c);
    rx_byte(8'ha5, 1'b1);
    rx_byte(8'hc3, 1'b0);
    rd_chk("rx word", ADDR_RXDATA, 16'h00c3);
    u_host.reg_rd(ADDR_STATUS, d);
  endtask : t_rx

  task automatic t_tone();
    {evt.ctcss_en, evt.ctcss_code} = {1'b1, 6'd5};
    tick(2);
    rd_chk("tone", ADDR_TONE, 16'h0005);
    rd_chk("status", ADDR_STATUS, 16'h0801);
    {evt.selcall_en, evt.selcall_code} = {1'b1, 5'd3};
    tick(2);
    rd_chk("tone", ADDR_TONE, 16'h1805);
    rd_chk("status", ADDR_STATUS, 16'h2001);
    {evt.dcs_en, evt.subaudio_code, evt.ctcss_code} = {1'b1, 3'b010, 6'd0};
    tick(2);
    rd_chk("tone", ADDR_TONE, 16'h1a00);
    rd_chk("status", ADDR_STATUS, 16'h0c01);
    evt.tx_mode = 1'b1;
    tick(2);
    rd_chk("tone", ADDR_TONE, 16'h0000);
    rd_chk("status", ADDR_STATUS, 16'h0001);
    evt.tx_last_done = 1'b1;
    tick();
    evt.tx_last_done = 1'b0;
    tick();
    rd_chk("status", ADDR_STATUS, 16'h0081);
    evt.selcall_en = 1'b0;
    evt.dcs_en = 1'b0;
    {evt.ctcss_en, evt.ctcss_code} = {1'b0, 6'd7};
    evt.tx_mode = 1'b0;
    tick(2);
    evt.tx_last_done = 1'b1;
    tick();
    evt.tx_last_done = 1'b0;
    tick();
    rd_chk("tone", ADDR_TONE, 16'h0000);
    rd_chk("status", ADDR_STATUS, 16'h0001);
  endtask : t_tone

  task automatic t_race();
    // transmit mode: a byte request raises the transfer flag
    evt.tx_mode = 1'b1;
    fork
      u_host.reg_rd(ADDR_STATUS, d);
      begin
        evt.xfer_req = 1'b1;
        tick();
        evt.xfer_req = 1'b0;
      end
    join
    `CHK("status", 16'h0001, d)
    rd_chk("status", ADDR_STATUS, 16'h0041);
    evt.tx_mode = 1'b0;
  endtask : t_race

  task automatic t_prog();
    logic [15:0] pw [6] = '{16'hc123, 16'h4456, 16'hd0ff, 16'he7ff, 16'h9abc, 16'h1234};
    bbsr_blk_t   pb [6] = '{BBSR_BLK0, BBSR_BLK0, BBSR_BLK1, BBSR_BLK2, BBSR_BLK4, BBSR_BLK4};
    logic [4:0]  px [6] = '{5'd0, 5'd1, 5'd0, 5'd0, 5'd0, 5'd1};
    logic [13:0] pd [6] = '{14'h0123, 14'h0456, 14'h00ff, 14'h07ff, 14'h1abc, 14'h1234};
    int          n;
    for (int i = 0; i < 6; i++) begin
      n = prog_cnt;
      u_host.prog_wr(pw[i], ok);
      `CHK("ready", 1'b1, ok)
      tick(3);
      `CHK("prog count", n + 1, prog_cnt)
      `CHK("prog word", bbsr_prog_t'{1'b1, pb[i], px[i], pd[i]}, last_prog)
      rd_chk("status", ADDR_STATUS, 16'h0000);
    end
    n = prog_cnt;
    u_host.prog_wr(16'hf000, ok);
    tick(3);
    `CHK("prog count", n, prog_cnt)
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    `CHK("prog word", '0, prog_word)
    rd_chk("status", ADDR_STATUS, 16'h0001);
  endtask : t_prog

  initial begin
    tick(6);
    rst = 1'b0;
    t_reset();
    t_adc();
    t_irq(16'h8040, 16'h8041, 1'b0);
    t_irq(16'h8080, 16'h0041, 1'b1);
    t_irq(16'h0040, 16'h8041, 1'b1);
    irq_mask = 16'h0000;
    t_sync();
    t_rx();
    t_tone();
    t_race();
    t_prog();
    tally_and_finish();
  end

  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : baseband_status_and_programming_regs_bench
